// ---- logic/spi_port_regs.svh ----
// Register map, field positions, reset values and clock divides of the serial port.
// Assumes one includer per compile unit; the guard keeps repeats harmless.
//
// What this block does
// - Unselected slave releases its data-out pin to high impedance.
// - Master shows each data-out bit half a clock before the slave latches it.
// - One byte moves both ways at once over eight master-driven clock cycles.
// - Master clock is system clock divided by 2, 4, 16 or 32; slave ignores it.
// - A master seeing its select input low sets the mode-fault flag.
// - Direction bit 5 makes select a plain output and disables mode-fault detection.
// - Phase 0 shifts only while select is low; select rises between bytes.
// - Mode fault clears master bit and four direction bits, then requests interrupt.
// - Data write during a transfer sets collision; transfer continues, byte discarded.
// - Only a master data write starts a byte; both ends flag its completion.
// - Phase 0 slave runs select-low to select-high; flags mid eighth cycle.
// - Phase 1 slave starts at first active clock edge, ends at completion flag.
// - Open-drain bit switches all port pins between push-pull and open-drain.
// - Control bits 7, 6, 4 are interrupt enable, port on, master; reset clears.
// - Idle clock level follows polarity bit; reset leaves phase bit set.
// - Completion flag requests interrupt; clears by status read then data access.
// - Data writes are ignored while completion is set and not yet seen.
// - Collision clears by status read seeing it, then a data access.
// - Mode fault clears by status read seeing it, then a control write.
// - Data reads return the receive buffer; unread buffer is kept on overrun.
`ifndef SPI_PORT_REGS_SVH
`define SPI_PORT_REGS_SVH

// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define IDX_CONTROL 8'h28
`define IDX_STATUS 8'h29
`define IDX_DATA 8'h2a
`define IDX_DIRECTION 8'h2b

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define ST_COMPLETE 7
`define ST_COLLISION 6
`define ST_FAULT 4
`define DIR_SELECT 5
`define DIR_CLOCK 4
`define DIR_DATA_OUT 3
`define DIR_DATA_IN 2
`define DIR_LEVEL 0
`define CONTROL_RESET 8'h04
`define DIRECTION_RESET 8'h00

// ----------------------------------------
// Half periods of the master clock in system clocks, last edge and bit indices, bus response codes
// ----------------------------------------
`define HALF_DIV2 5'h01
`define HALF_DIV4 5'h02
`define HALF_DIV16 5'h08
`define HALF_DIV32 5'h10
`define LAST_EDGE 4'hf
`define LAST_BIT 3'h7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- logic/spi_port_pkg.sv ----
// Types shared by the serial port and whoever instantiates it.
// Assumes the register header supplies all numeric constants.
package spi_port_pkg;
	// Control register fields, bit 7 down to bit 0
	typedef struct packed {
		logic port_interrupt_enable;
		logic port_on;
		logic open_drain_select;
		logic master_select;
		logic cpol;
		logic cpha;
		logic [1:0] clock_rate_field;
	} control_t;
	// One bit per serial pin
	typedef struct packed {
		logic ss;
		logic sck;
		logic mosi;
		logic miso;
	} pins_t;
	typedef enum logic {M_IDLE, M_RUN} master_state_t;
	typedef enum logic [1:0] {SEL_CONTROL, SEL_STATUS, SEL_DATA, SEL_DIRECTION} reg_sel_t;
endpackage : spi_port_pkg

// ---- logic/spi_master_slave_port.sv ----
// Serial port that runs as bus master or slave, with an AXI4-Lite register slave.
// Assumes aclk is the system clock; pins arrive unsynchronised and leave as in/out/enable.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "spi_port_regs.svh"

module spi_master_slave_port
	import spi_port_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic ce, // Clock enable, freezes all state when low
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire pins_t pin_in, // Pin levels seen from outside
	output pins_t pin_out, // Pin drive values
	output pins_t pin_oe, // Pin output enables, high drives
	output logic irq // Interrupt request, active high
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (ADDR_W < 10) begin : g_addr_check
		$error("ADDR_W must reach the port registers");
	end

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Word index to register select; bad index flagged separately
	function automatic logic decode_ok(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-3:0] i;
		i = a[ADDR_W-1:2];
		decode_ok = (i >= (ADDR_W-2)'(`IDX_CONTROL)) && (i <= (ADDR_W-2)'(`IDX_DIRECTION));
	endfunction : decode_ok

	function automatic reg_sel_t decode_sel(input logic [ADDR_W-1:0] a);
		logic [1:0] low;
		low = a[3:2];
		decode_sel = reg_sel_t'(low);
	endfunction : decode_sel

	// Half period of master clock for a rate code
	function automatic logic [4:0] half_period(input logic [1:0] code);
		unique case (code)
			2'h0: half_period = `HALF_DIV2;
			2'h1: half_period = `HALF_DIV4;
			2'h2: half_period = `HALF_DIV16;
			2'h3: half_period = `HALF_DIV32;
		endcase
	endfunction : half_period

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	control_t ctrl_q;
	logic [7:0] dir_q;
	logic complete_q, collision_q, fault_q;
	logic complete_seen_q, collision_seen_q, fault_seen_q;
	logic [7:0] rx_buf_q, shift_q;
	logic out_bit_q, sck_q;
	master_state_t m_state_q;
	logic [4:0] pre_q;
	logic [3:0] edge_q;
	logic s_busy_q;
	logic [2:0] s_bits_q;
	pins_t sync1_q, sync2_q;
	logic sck_prev_q, ss_prev_q;
	logic aw_have_q, w_have_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [7:0] wdata_q;
	logic wstrb0_q;
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	pins_t out_q, oe_q;
	logic irq_q;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Two flops per pin; only the second stage feeds logic
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q <= '1;
			sync2_q <= '1;
			sck_prev_q <= 1'b1;
			ss_prev_q <= 1'b1;
		end else if (ce) begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
			sck_prev_q <= sync2_q.sck;
			ss_prev_q <= sync2_q.ss;
		end
	end

	// ----------------------------------------
	// Bus decode and event terms
	// ----------------------------------------
	logic wr_go, rd_go, wr_ok, rd_ok, fault_now, busy, data_wr, data_rd, data_acc;
	logic wr_accept, start_m, done, s_sel, s_lead, s_trail, ss_fall, m_tick, m_lead;
	logic [7:0] done_byte;
	reg_sel_t wr_sel, rd_sel;

	assign wr_go = ce && aw_have_q && w_have_q && !bvalid_q;
	assign rd_go = ce && s_axi_arvalid && arready_q;
	assign wr_ok = decode_ok(awaddr_q);
	assign rd_ok = decode_ok(s_axi_araddr);
	assign wr_sel = decode_sel(awaddr_q);
	assign rd_sel = decode_sel(s_axi_araddr);
	// Only the low byte lane carries register data
	assign data_wr = wr_go && wr_ok && wstrb0_q && wr_sel == SEL_DATA;
	assign data_rd = rd_go && rd_ok && rd_sel == SEL_DATA;
	assign data_acc = data_wr || data_rd;
	assign busy = (m_state_q == M_RUN) || s_busy_q;
	// Write blocked while completion is pending and unseen
	assign wr_accept = data_wr && !busy && (!complete_q || complete_seen_q);
	assign start_m = wr_accept && ctrl_q.port_on && ctrl_q.master_select;
	// Select low on an enabled master whose select pin is still an input
	assign fault_now = ctrl_q.port_on && ctrl_q.master_select
		&& !dir_q[`DIR_SELECT] && !sync2_q.ss;
	// Slave shift clock is gated by select, the OR form of phase 0
	assign s_sel = ctrl_q.port_on && !ctrl_q.master_select && !sync2_q.ss;
	assign s_lead = s_sel && (sync2_q.sck != sck_prev_q) && (sync2_q.sck != ctrl_q.cpol);
	assign s_trail = s_sel && (sync2_q.sck != sck_prev_q) && (sync2_q.sck == ctrl_q.cpol);
	assign ss_fall = ctrl_q.port_on && !ctrl_q.master_select && ss_prev_q && !sync2_q.ss;
	assign m_tick = (m_state_q == M_RUN) && (pre_q == half_period(ctrl_q.clock_rate_field) - 5'h01);
	assign m_lead = !edge_q[0];

	// Byte completion and the byte captured with it
	always_comb begin
		done = 1'b0;
		done_byte = {shift_q[6:0], sync2_q.miso};
		if (m_tick && edge_q == `LAST_EDGE) begin
			done = 1'b1;
			done_byte = ctrl_q.cpha ? {shift_q[6:0], sync2_q.miso} : shift_q;
		end else if (s_bits_q == `LAST_BIT && (ctrl_q.cpha ? s_trail : s_lead)) begin
			done = 1'b1;
			done_byte = {shift_q[6:0], sync2_q.mosi};
		end
	end

	// ----------------------------------------
	// Control and direction registers
	// ----------------------------------------
	// Fault forces slave and releases all port drivers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= control_t'(`CONTROL_RESET);
			dir_q <= `DIRECTION_RESET;
		end else if (ce) begin
			if (wr_go && wr_ok && wstrb0_q && wr_sel == SEL_CONTROL)
				ctrl_q <= control_t'(wdata_q);
			if (wr_go && wr_ok && wstrb0_q && wr_sel == SEL_DIRECTION)
				dir_q <= wdata_q;
			if (fault_now) begin
				ctrl_q.master_select <= 1'b0;
				dir_q[`DIR_SELECT:`DIR_DATA_IN] <= 4'h0;
			end
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	// A set in the same cycle as a clear wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			complete_q <= 1'b0;
			collision_q <= 1'b0;
			fault_q <= 1'b0;
			complete_seen_q <= 1'b0;
			collision_seen_q <= 1'b0;
			fault_seen_q <= 1'b0;
		end else if (ce) begin
			if (rd_go && rd_ok && rd_sel == SEL_STATUS) begin
				complete_seen_q <= complete_q;
				collision_seen_q <= collision_q;
				fault_seen_q <= fault_q;
			end
			if (data_acc && complete_seen_q) begin
				complete_q <= 1'b0;
				complete_seen_q <= 1'b0;
			end
			if (data_acc && collision_seen_q) begin
				collision_q <= 1'b0;
				collision_seen_q <= 1'b0;
			end
			if (wr_go && wr_ok && wr_sel == SEL_CONTROL && fault_seen_q) begin
				fault_q <= 1'b0;
				fault_seen_q <= 1'b0;
			end
			if (done)
				complete_q <= 1'b1;
			if (data_wr && busy)
				collision_q <= 1'b1;
			if (fault_now)
				fault_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Receive buffer
	// ----------------------------------------
	// An unread byte is kept; the newer one is lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_buf_q <= 8'h00;
		end else if (ce) begin
			if (done && !complete_q)
				rx_buf_q <= done_byte;
		end
	end

	// ----------------------------------------
	// Master clock generator
	// ----------------------------------------
	// Prescaler counts system clocks per half period
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			m_state_q <= M_IDLE;
			pre_q <= 5'h00;
			edge_q <= 4'h0;
			sck_q <= 1'b0;
		end else if (ce) begin
			unique case (m_state_q)
				M_IDLE: begin
					sck_q <= ctrl_q.cpol;
					pre_q <= 5'h00;
					edge_q <= 4'h0;
					if (start_m)
						m_state_q <= M_RUN;
				end
				M_RUN: begin
					pre_q <= m_tick ? 5'h00 : pre_q + 5'h01;
					if (m_tick) begin
						sck_q <= !sck_q;
						edge_q <= edge_q + 4'h1;
						if (edge_q == `LAST_EDGE)
							m_state_q <= M_IDLE;
					end
					if (fault_now)
						m_state_q <= M_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Slave transfer tracking
	// ----------------------------------------
	// Phase 0 stays busy until select rises, phase 1 until the byte ends
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_busy_q <= 1'b0;
			s_bits_q <= 3'h0;
		end else if (ce) begin
			if (!s_sel) begin
				s_busy_q <= 1'b0;
				s_bits_q <= 3'h0;
			end else begin
				if (!ctrl_q.cpha && ss_fall)
					s_busy_q <= 1'b1;
				if (ctrl_q.cpha && s_lead)
					s_busy_q <= 1'b1;
				if (ctrl_q.cpha ? s_trail : s_lead) begin
					s_bits_q <= s_bits_q + 3'h1;
					if (ctrl_q.cpha && s_bits_q == `LAST_BIT)
						s_busy_q <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// Shifter and serial output bit
	// ----------------------------------------
	// One shifter serves both roles since only one is active at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_q <= 8'h00;
			out_bit_q <= 1'b0;
		end else if (ce) begin
			if (wr_accept) begin
				shift_q <= wdata_q;
				if (!ctrl_q.cpha)
					out_bit_q <= wdata_q[7];
			end else if (m_tick) begin
				if (m_lead == !ctrl_q.cpha)
					shift_q <= {shift_q[6:0], sync2_q.miso};
				else
					out_bit_q <= shift_q[7];
			end else if (ss_fall && !ctrl_q.cpha) begin
				out_bit_q <= shift_q[7];
			end else if (ctrl_q.cpha ? s_trail : s_lead) begin
				shift_q <= {shift_q[6:0], sync2_q.mosi};
			end else if (ctrl_q.cpha ? s_lead : s_trail) begin
				out_bit_q <= shift_q[7];
			end
		end
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	// Open-drain mode drives only lows, releasing highs to the pull-up
	pins_t val_d, en_d;
	always_comb begin
		val_d.ss = dir_q[`DIR_LEVEL];
		val_d.sck = sck_q;
		val_d.mosi = out_bit_q;
		val_d.miso = out_bit_q;
		en_d.ss = ctrl_q.port_on && dir_q[`DIR_SELECT];
		en_d.sck = ctrl_q.port_on && ctrl_q.master_select && dir_q[`DIR_CLOCK];
		en_d.mosi = ctrl_q.port_on && ctrl_q.master_select && dir_q[`DIR_DATA_OUT];
		en_d.miso = s_sel && dir_q[`DIR_DATA_IN];
		if (ctrl_q.open_drain_select)
			en_d = en_d & ~val_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_q <= '0;
			oe_q <= '0;
			irq_q <= 1'b0;
		end else if (ce) begin
			out_q <= val_d;
			oe_q <= en_d;
			irq_q <= ctrl_q.port_interrupt_enable && (complete_q || fault_q);
		end
	end

	// ----------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------
	// Address and data are caught in either order, answered once both are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 8'h00;
			wstrb0_q <= 1'b0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= `RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && awready_q) begin
				aw_have_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
				awready_q <= 1'b0;
			end
			if (s_axi_wvalid && wready_q) begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata[7:0];
				wstrb0_q <= s_axi_wstrb[0];
				wready_q <= 1'b0;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------
	// Reserved status bits and upper lanes read as zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `RESP_OKAY;
		end else if (ce) begin
			if (rd_go) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rresp_q <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
				rdata_q <= 32'h0000_0000;
				if (rd_ok) begin
					unique case (rd_sel)
						SEL_CONTROL: rdata_q[7:0] <= ctrl_q;
						SEL_STATUS: begin
							rdata_q[`ST_COMPLETE] <= complete_q;
							rdata_q[`ST_COLLISION] <= collision_q;
							rdata_q[`ST_FAULT] <= fault_q;
						end
						SEL_DATA: rdata_q[7:0] <= rx_buf_q;
						SEL_DIRECTION: rdata_q[7:0] <= dir_q;
					endcase
				end
			end
			if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Output assignments
	// ----------------------------------------
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign pin_out = out_q;
	assign pin_oe = oe_q;
	assign irq = irq_q;

endmodule : spi_master_slave_port

// ---- verif/spi_port_asserts.sv ----
// Concurrent checks on the serial port's bus and pin ports.
// Assumes the bind at the foot; sees top-level ports only.
`timescale 1ns/1ps
module spi_port_asserts
	import spi_port_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, active low
	input wire logic s_axi_awvalid, // Write address valid
	input wire logic s_axi_awready, // Write address ready
	input wire logic s_axi_wvalid, // Write data valid
	input wire logic s_axi_wready, // Write data ready
	input wire logic [1:0] s_axi_bresp, // Write response
	input wire logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	input wire logic s_axi_arready, // Read address ready
	input wire logic [31:0] s_axi_rdata, // Read data
	input wire logic [1:0] s_axi_rresp, // Read response
	input wire logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire pins_t pin_in, // Pin levels
	input wire pins_t pin_out, // Pin drive values
	input wire pins_t pin_oe, // Pin enables
	input wire logic irq // Interrupt request
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic sck_q;
	logic [4:0] tgl_q;
	// ----------------------------------------
	// Clock toggles since the last interrupt rise
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		sck_q <= pin_out.sck;
		if (!aresetn || $rose(irq))
			tgl_q <= 5'h00;
		else if (pin_oe.sck && pin_out.sck != sck_q)
			tgl_q <= tgl_q + 5'h01;
	end
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_b_time;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	// Unmapped reads answer with an error and zero data
	property p_r_err;
		s_axi_arvalid && s_axi_arready && (s_axi_araddr >> 4) != 'h0a
			|=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
	endproperty
	property p_miso_hiz;
		pin_in.ss [*4] |-> !pin_oe.miso;
	endproperty
	// Contention guard: a master seeing select low drops its drivers
	property p_fault_release;
		(pin_oe.sck && !pin_oe.ss && !pin_in.ss) [*5] |=> !pin_oe.sck;
	endproperty
	// The last toggle shows in the cycle the interrupt rises, so add it here
	property p_sck_count;
		$rose(irq) && tgl_q != 5'h00 |-> tgl_q + 5'($changed(pin_out.sck)) == 5'h10;
	endproperty
	property p_sck_rest;
		$rose(irq) |=> $stable(pin_out.sck) [*2];
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response changed before it was taken");
	a_r_hold: assert property (p_r_hold)
		else $error("read data changed before it was taken");
	a_b_time: assert property (p_b_time)
		else $error("write response late");
	a_r_err: assert property (p_r_err)
		else $error("unmapped read not answered with error");
	a_miso_hiz: assert property (p_miso_hiz)
		else $error("data out driven while not selected");
	a_fault_release: assert property (p_fault_release)
		else $error("clock driver kept after select went low");
	a_sck_count: assert property (p_sck_count)
		else $error("byte did not take sixteen clock edges");
	a_sck_rest: assert property (p_sck_rest)
		else $error("clock moved right after a byte");
	c_xfer: cover property ($rose(irq) && tgl_q == 5'h0f);
	c_fault: cover property ($fell(pin_oe.sck));
	c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : spi_port_asserts

bind spi_master_slave_port spi_port_asserts #(.ADDR_W(ADDR_W)) checker_inst (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.pin_in(pin_in),
	.pin_out(pin_out),
	.pin_oe(pin_oe),
	.irq(irq)
);

// ---- verif/spi_slave_model.sv ----
// Behavioural serial slave, phase 1 and polarity 0, answering each byte with tx_byte.
// Assumes the master keeps select low over whole bytes.
`timescale 1ns/1ps
module spi_slave_model (
	input wire logic sck, // Serial clock from the master
	input wire logic ss_n, // Select, active low
	input wire logic mosi, // Data from the master
	input wire logic [7:0] tx_byte, // Byte returned
	output logic miso, // Data to the master
	output logic [7:0] rx_byte // Last eight bits received
);
	logic [7:0] sh = 8'h00;
	logic [2:0] cnt = 3'h0;
	initial miso = 1'b0;
	initial rx_byte = 8'h00;
	// Drive on the leading edge, MSB first; a byte reloads after eight bits
	always @(posedge sck) begin
		if (!ss_n) begin
			miso <= cnt == 3'h0 ? tx_byte[7] : sh[7];
			sh <= cnt == 3'h0 ? {tx_byte[6:0], 1'b0} : {sh[6:0], 1'b0};
			cnt <= cnt + 3'h1;
		end
	end
	// Sample on the trailing edge
	always @(negedge sck) begin
		if (!ss_n)
			rx_byte <= {rx_byte[6:0], mosi};
	end
	// Released line flips so a stale bit is never mistaken for data
	always @(posedge ss_n) miso <= ~miso;
endmodule : spi_slave_model

// ---- verif/tb_spi_master_slave_port.sv ----
// Self-checking bench: register tasks over the bus, a serial partner, expected values.
// Assumes the register header and package are compiled first.
`timescale 1ns/1ps
`include "spi_port_regs.svh"
module tb_spi_master_slave_port
	import spi_port_pkg::*;
;
	localparam logic [11:0] CTL = {2'b00, `IDX_CONTROL, 2'b00};
	localparam logic [11:0] STS = {2'b00, `IDX_STATUS, 2'b00};
	localparam logic [11:0] DAT = {2'b00, `IDX_DATA, 2'b00};
	localparam logic [11:0] DIR = {2'b00, `IDX_DIRECTION, 2'b00};
	localparam int HALF [4] = '{`HALF_DIV2, `HALF_DIV4, `HALF_DIV16, `HALF_DIV32};
	logic aclk, aresetn = 1'b0, ce = 1'b1, ss_ext = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h1;
	logic awready, wready, bvalid, arready, rvalid, irq, miso, sck_d;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] slave_tx = 8'h00;
	logic [7:0] slave_rx;
	pins_t pin_in, pin_out, pin_oe;
	int error_cnt = 0, samples_checked = 0, hi_cnt = 0, rise_cnt = 0, r0;

	spi_master_slave_port dut (
		.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .irq(irq)
	);
	spi_slave_model partner (.sck(pin_in.sck), .ss_n(pin_in.ss), .mosi(pin_in.mosi),
		.tx_byte(slave_tx), .miso(miso), .rx_byte(slave_rx));
	// Wire levels; an undriven data line toggles rather than holding a value
	assign pin_in = {pin_oe.ss ? pin_out.ss : ss_ext, pin_oe.sck & pin_out.sck,
		pin_oe.mosi ? pin_out.mosi : aclk, miso};

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	// Count master clock high cycles and rising edges
	always @(posedge aclk) begin
		sck_d <= pin_out.sck;
		if (pin_oe.sck && pin_out.sck)
			hi_cnt <= hi_cnt + 1;
		if (pin_oe.sck && pin_out.sck && !sck_d)
			rise_cnt <= rise_cnt + 1;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	// Address and data offered together; bready held until the answer
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask : wr
	task automatic rchk(input logic [11:0] a, input logic [7:0] e,
		input logic [7:0] m = 8'hff, input logic [1:0] er = 2'h0);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata & {24'hffffff, m}, {24'h0, e & m});
		chk({30'h0, rresp}, {30'h0, er});
	endtask : rchk
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge aclk);
			n++;
		end
		if (irq !== 1'b1)
			error_cnt++;
	endtask : wait_irq
	// One master byte at a given rate; received data is only exact at slow rates
	task automatic xfer(input logic [1:0] rt, input logic [7:0] tx, input logic [7:0] rx);
		int h0;
		h0 = hi_cnt;
		r0 = rise_cnt;
		slave_tx <= rx;
		wr(CTL, 8'hd4 | rt);
		wr(DAT, tx);
		wait_irq();
		chk(32'(hi_cnt - h0), 32'(8 * HALF[rt]));
		chk(32'(rise_cnt - r0), 32'h8);
		chk({24'h0, slave_rx}, {24'h0, tx});
		rchk(STS, 8'h80);
		rchk(DAT, rx, rt > 2'h1 ? 8'hff : 8'h00);
		rchk(STS, 8'h00);
		chk({31'h0, irq}, 32'h0);
	endtask : xfer
	task automatic summarize();
		$display("errors %0d, checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(CTL, 8'h04);
		rchk(STS, 8'h00);
		rchk(DIR, 8'h00);
		rchk(12'h0b0, 8'h00, 8'hff, 2'h2);
		wr(12'h0b0, 8'hff, 2'h2);
		wr(DIR, 8'h38);
		rchk(DIR, 8'h38);
		for (int r = 0; r < 4; r++)
			xfer(2'(r), 8'ha5 ^ 8'(r), 8'h3c + 8'(r));
		// Write mid-byte collides; a write before the status read is ignored
		slave_tx <= 8'h96;
		wr(CTL, 8'hd7);
		wr(DAT, 8'h5a);
		wr(DAT, 8'hff);
		wait_irq();
		chk({24'h0, slave_rx}, 32'h5a);
		r0 = rise_cnt;
		wr(DAT, 8'h77);
		repeat (40) @(posedge aclk);
		chk(32'(rise_cnt - r0), 32'h0);
		rchk(STS, 8'hc0);
		rchk(DAT, 8'h96);
		rchk(STS, 8'h00);
		// Select pulled low under a master
		wr(DIR, 8'h39);
		wr(DIR, 8'h18);
		rchk(STS, 8'h00);
		ss_ext <= 1'b0;
		wait_irq();
		chk({31'h0, irq}, 32'h1);
		rchk(CTL, 8'hc7);
		rchk(DIR, 8'h00);
		ss_ext <= 1'b1;
		wr(CTL, 8'h44);
		rchk(STS, 8'h10);
		wr(CTL, 8'h44);
		rchk(STS, 8'h00);
		// Slave drives data out only while selected
		wr(DIR, 8'h04);
		ss_ext <= 1'b0;
		repeat (6) @(posedge aclk);
		chk({31'h0, pin_oe.miso}, 32'h1);
		ss_ext <= 1'b1;
		repeat (6) @(posedge aclk);
		chk({31'h0, pin_oe.miso}, 32'h0);
		summarize();
	end
	// Tests need about 1000 cycles; cut off well beyond
	initial begin
		repeat (60000) @(posedge aclk);
		error_cnt++;
		summarize();
	end
endmodule : tb_spi_master_slave_port
